/* File: hw/qps_pkg.sv */
// Shared constants and types for the quad potentiometer serial slave.
package qps_pkg;
    // Device type code; the value is arbitrary.
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_STORE = 4'hB;
    localparam logic [3:0] OP_WR_STORE = 4'hC;
    localparam logic [3:0] OP_COPY_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_COPY_TO_STORE = 4'hE;
    localparam logic [3:0] OP_GCOPY_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_GCOPY_TO_STORE = 4'h8;
    localparam logic [3:0] OP_INCDEC = 4'h2;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [5:0] TAP_MAX = 6'h3F;
    localparam logic [5:0] WIPER_RST = 6'h00;
    localparam logic [5:0] STORE_RST = 6'h00;
    localparam int CLK_MHZ = 20;
    localparam int NV_WRITE_MS = 10;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_MHZ * 1000;
    localparam int NV_CNT_W = 18;
    // Settle figure is not given; plain default.
    localparam int WIPER_SETTLE_NS = 1000;
    localparam int WIPER_SETTLE_CYC = (WIPER_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_INSTR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_INCDEC = 3'b101
    } qps_stage_e;
endpackage : qps_pkg

/* File: hw/qps_quad_pot_slave.sv */
// Two-wire command slave driving four 64-tap wipers.
// Behaviour
// - Data rising while clock high ends transaction.
// - Receiver pulls data low on ninth clock.
// - Acknowledge address, instruction and data byte.
// - Upper address nibble must equal device type.
// - Lower address nibble must equal strap pins.
// - Stop starts nonvolatile write; busy refuses address.
// - Instruction: opcode, register index, pot index.
// - Four copy instructions carry no data byte.
// - Copy into wiper reaches taps after settling.
// - Copy into store lasts the write time.
// - Copies act on one pot or all.
// - Wiper and store read/write use three bytes.
// - Step clock with data high moves wiper up.
// - Step clock with data low moves wiper down.
// - Read and write the wiper position.
// - Read and write a stored setting.
// - Copy store to wiper, wiper to store.
// - Global copies in both directions.
// - Increment/decrement opcode enables stepping.
// - Each wiper drives exactly one tap.
// - Falling data with clock high starts command.
// - Data changes only while clock low.
// - Low write lock blocks nonvolatile writes.
`timescale 1ns/1ps
module qps_quad_pot_slave #(
    parameter int NV_WRITE_CYC = qps_pkg::NV_WRITE_CYC
) (
    input wire logic clk, // System clock.
    input wire logic sys_rst, // Reset, active high; synchronous for the clk logic, asynchronous for the serial-clock logic.
    input wire logic scl_in, // Serial clock from the master.
    input wire logic sda_in, // Serial data level on the wire.
    output logic sda_o, // Serial data output value.
    output logic sda_oe_n, // Low while pulling data low.
    input wire logic [3:0] address_strap_inputs, // Device address straps.
    input wire logic write_lock_n, // Low blocks stored writes.
    output logic nv_busy, // Nonvolatile write in progress.
    output logic [3:0][63:0] wiper_tap_sel // One-hot tap per pot.
);
    typedef struct packed {
        qps_pkg::qps_stage_e stage;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] instr;
        logic [7:0] tx;
        logic ack;
        logic start_seen;
        logic stop_seen;
        logic [3:0] strap_s1;
        logic [3:0] strap_s2;
        logic busy_s1;
        logic busy_s2;
        logic take_s1;
        logic take_s2;
        logic take_seen;
        logic [3:0][5:0] wiper_position_reg;
        logic nv_pend;
        logic [3:0] nv_mask;
        logic [1:0] nv_idx;
        logic [3:0][5:0] nv_data;
    } qps_link_s;

    typedef struct packed {
        logic sda_oe_n;
        logic sda_o;
    } qps_drv_s;

    typedef struct packed {
        logic stop_s1;
        logic stop_s2;
        logic stop_s3;
        logic pend_s1;
        logic pend_s2;
        logic wp_s1;
        logic wp_s2;
        logic take_tgl;
        logic [3:0][5:0] w_s1;
        logic [3:0][5:0] w_s2;
        logic [3:0][5:0] w_s3;
        logic [3:0][5:0] tgt;
        logic [qps_pkg::SETTLE_W-1:0] settle;
        logic [3:0][63:0] taps;
        logic busy;
        logic [qps_pkg::NV_CNT_W-1:0] nvcnt;
        logic [3:0] lat_mask;
        logic [1:0] lat_idx;
        logic [3:0][5:0] lat_data;
        logic [3:0][3:0][5:0] stored_setting_reg;
    } qps_sys_s;

    qps_link_s lr;
    qps_link_s ln;
    qps_drv_s dr_r;
    qps_drv_s dr_nxt;
    qps_sys_s sr;
    qps_sys_s sn;
    logic start_tgl_r;
    logic stop_tgl_r;
    logic [7:0] byte_in;
    logic link_quiet;
    logic stop_edge;

    function automatic logic [63:0] qps_onehot(input logic [5:0] pos);
        qps_onehot = 64'h1 << pos;
    endfunction : qps_onehot

    function automatic logic qps_legal(input logic [7:0] ins);
        logic zr;
        logic zp;
        zr = (ins[3:2] == 2'h0);
        zp = (ins[1:0] == 2'h0);
        unique case (ins[7:4])
            qps_pkg::OP_RD_WIPER, qps_pkg::OP_WR_WIPER, qps_pkg::OP_INCDEC: qps_legal = zr;
            qps_pkg::OP_RD_STORE, qps_pkg::OP_WR_STORE: qps_legal = 1'b1;
            qps_pkg::OP_COPY_TO_WIPER, qps_pkg::OP_COPY_TO_STORE: qps_legal = 1'b1;
            qps_pkg::OP_GCOPY_TO_WIPER, qps_pkg::OP_GCOPY_TO_STORE: qps_legal = zp;
            default: qps_legal = 1'b0;
        endcase
    endfunction : qps_legal

    // Start and stop are the only data edges while the clock is high, so
    // they clock their own toggles; the bit logic compares at clock rise.
    // The clock may stand still, hence the asynchronous reset here.
    always_ff @(negedge sda_in or posedge sys_rst)
    begin
        if (sys_rst)
            start_tgl_r <= 1'b0;
        else if (scl_in)
            start_tgl_r <= ~start_tgl_r;
    end

    always_ff @(posedge sda_in or posedge sys_rst)
    begin
        if (sys_rst)
            stop_tgl_r <= 1'b0;
        else if (scl_in)
            stop_tgl_r <= ~stop_tgl_r;
    end

    assign byte_in = {lr.sh[6:0], sda_in};
    assign link_quiet = (start_tgl_r == lr.start_seen) && (stop_tgl_r == lr.stop_seen);

    always_comb
    begin
        logic [1:0] p;
        logic [1:0] ri;
        p = lr.instr[1:0];
        ri = lr.instr[3:2];
        ln = lr;
        ln.strap_s1 = address_strap_inputs;
        ln.strap_s2 = lr.strap_s1;
        ln.busy_s1 = sr.busy;
        ln.busy_s2 = lr.busy_s1;
        ln.take_s1 = sr.take_tgl;
        ln.take_s2 = lr.take_s1;
        if (lr.take_s2 != lr.take_seen)
        begin
            ln.take_seen = lr.take_s2;
            ln.nv_pend = 1'b0;
        end
        if (start_tgl_r != lr.start_seen)
        begin
            ln.start_seen = start_tgl_r;
            ln.stop_seen = stop_tgl_r;
            ln.stage = qps_pkg::ST_ADDR;
            ln.sh = byte_in;
            ln.bitcnt = 4'h1;
            ln.ack = 1'b0;
        end
        else if (stop_tgl_r != lr.stop_seen)
        begin
            ln.stop_seen = stop_tgl_r;
            ln.stage = qps_pkg::ST_IDLE;
            ln.bitcnt = 4'h0;
            ln.ack = 1'b0;
        end
        else
        begin
            unique case (lr.stage)
                qps_pkg::ST_IDLE:
                begin
                end
                qps_pkg::ST_INCDEC:
                begin
                    // Bits are sampled while the clock is high.
                    if (sda_in && lr.wiper_position_reg[p] != qps_pkg::TAP_MAX)
                        ln.wiper_position_reg[p] = lr.wiper_position_reg[p] + 6'h01;
                    else if (!sda_in && lr.wiper_position_reg[p] != 6'h00)
                        ln.wiper_position_reg[p] = lr.wiper_position_reg[p] - 6'h01;
                end
                qps_pkg::ST_ADDR, qps_pkg::ST_INSTR, qps_pkg::ST_WDATA, qps_pkg::ST_RDATA:
                begin
                    if (lr.bitcnt < qps_pkg::BIT_ACK)
                    begin
                        ln.sh = byte_in;
                        ln.tx = {lr.tx[6:0], 1'b0};
                        ln.bitcnt = lr.bitcnt + 4'h1;
                    end
                    if (lr.bitcnt == qps_pkg::BIT_LAST)
                    begin
                        unique case (lr.stage)
                            qps_pkg::ST_ADDR:
                                // A match is refused while the stored write runs.
                                ln.ack = byte_in[7:4] == qps_pkg::DEV_TYPE
                                    && byte_in[3:0] == lr.strap_s2 && !lr.busy_s2;
                            qps_pkg::ST_INSTR:
                            begin
                                ln.instr = byte_in;
                                ln.ack = qps_legal(byte_in);
                                if (qps_legal(byte_in))
                                begin
                                    unique case (byte_in[7:4])
                                        qps_pkg::OP_COPY_TO_WIPER:
                                            ln.wiper_position_reg[byte_in[1:0]] =
                                                sr.stored_setting_reg[byte_in[3:2]][byte_in[1:0]];
                                        qps_pkg::OP_GCOPY_TO_WIPER:
                                            ln.wiper_position_reg = sr.stored_setting_reg[byte_in[3:2]];
                                        qps_pkg::OP_COPY_TO_STORE, qps_pkg::OP_GCOPY_TO_STORE:
                                        begin
                                            ln.nv_pend = 1'b1;
                                            ln.nv_idx = byte_in[3:2];
                                            ln.nv_data = lr.wiper_position_reg;
                                            ln.nv_mask = (byte_in[7:4] == qps_pkg::OP_GCOPY_TO_STORE) ? 4'hF :
                                                4'(4'h1 << byte_in[1:0]);
                                        end
                                        default:
                                        begin
                                        end
                                    endcase
                                end
                            end
                            qps_pkg::ST_WDATA:
                            begin
                                ln.ack = 1'b1;
                                if (lr.instr[7:4] == qps_pkg::OP_WR_WIPER)
                                    ln.wiper_position_reg[p] = byte_in[5:0];
                                else
                                begin
                                    ln.nv_pend = 1'b1;
                                    ln.nv_idx = ri;
                                    ln.nv_mask = 4'(4'h1 << p);
                                    ln.nv_data[p] = byte_in[5:0];
                                end
                            end
                            default:
                                ln.ack = 1'b0;
                        endcase
                        if (!ln.ack && lr.stage != qps_pkg::ST_RDATA)
                        begin
                            ln.stage = qps_pkg::ST_IDLE;
                            ln.bitcnt = 4'h0;
                        end
                    end
                    if (lr.bitcnt == qps_pkg::BIT_ACK)
                    begin
                        ln.bitcnt = 4'h0;
                        ln.ack = 1'b0;
                        ln.stage = qps_pkg::ST_IDLE;
                        if (lr.stage == qps_pkg::ST_ADDR)
                            ln.stage = qps_pkg::ST_INSTR;
                        else if (lr.stage == qps_pkg::ST_INSTR)
                        begin
                            unique case (lr.instr[7:4])
                                qps_pkg::OP_RD_WIPER:
                                begin
                                    ln.stage = qps_pkg::ST_RDATA;
                                    ln.tx = {2'h0, lr.wiper_position_reg[p]};
                                end
                                qps_pkg::OP_RD_STORE:
                                begin
                                    ln.stage = qps_pkg::ST_RDATA;
                                    ln.tx = {2'h0, sr.stored_setting_reg[ri][p]};
                                end
                                qps_pkg::OP_WR_WIPER, qps_pkg::OP_WR_STORE:
                                    ln.stage = qps_pkg::ST_WDATA;
                                qps_pkg::OP_INCDEC:
                                    ln.stage = qps_pkg::ST_INCDEC;
                                default:
                                    ln.stage = qps_pkg::ST_IDLE;
                            endcase
                        end
                    end
                end
                default:
                    ln.stage = qps_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge scl_in or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lr <= '0;
            lr.stage <= qps_pkg::ST_IDLE;
            lr.wiper_position_reg <= {4{qps_pkg::WIPER_RST}};
        end
        else
            lr <= ln;
    end

    // The data pin changes only after the clock falls.
    always_comb
    begin
        dr_nxt.sda_o = 1'b0;
        dr_nxt.sda_oe_n = 1'b1;
        if (lr.bitcnt == qps_pkg::BIT_ACK && lr.ack)
            dr_nxt.sda_oe_n = 1'b0;
        else if (lr.stage == qps_pkg::ST_RDATA && lr.bitcnt < qps_pkg::BIT_ACK && !lr.tx[7])
            dr_nxt.sda_oe_n = 1'b0;
    end

    always_ff @(negedge scl_in or posedge sys_rst)
    begin
        if (sys_rst)
            dr_r <= '{sda_oe_n: 1'b1, sda_o: 1'b0};
        else
            dr_r <= dr_nxt;
    end

    assign stop_edge = sr.stop_s3 != sr.stop_s2;

    always_comb
    begin
        sn = sr;
        sn.stop_s1 = stop_tgl_r;
        sn.stop_s2 = sr.stop_s1;
        sn.stop_s3 = sr.stop_s2;
        sn.pend_s1 = lr.nv_pend;
        sn.pend_s2 = sr.pend_s1;
        sn.wp_s1 = write_lock_n;
        sn.wp_s2 = sr.wp_s1;
        sn.w_s1 = lr.wiper_position_reg;
        sn.w_s2 = sr.w_s1;
        sn.w_s3 = sr.w_s2;
        // Wiper bits cross unsynchronised as a word; only a word seen
        // unchanged on two clocks is taken, which rejects torn samples.
        if (sr.w_s2 == sr.w_s3 && sr.w_s3 != sr.tgt)
        begin
            sn.tgt = sr.w_s3;
            sn.settle = qps_pkg::SETTLE_W'(qps_pkg::WIPER_SETTLE_CYC);
        end
        else if (sr.settle != '0)
        begin
            sn.settle = sr.settle - 1'b1;
            if (sr.settle == qps_pkg::SETTLE_W'(1))
            begin
                for (int i = 0; i < 4; i++)
                    sn.taps[i] = qps_onehot(sr.tgt[i]);
            end
        end
        if (stop_edge && sr.pend_s2 && !sr.busy)
        begin
            sn.take_tgl = ~sr.take_tgl;
            if (sr.wp_s2)
            begin
                sn.busy = 1'b1;
                sn.nvcnt = qps_pkg::NV_CNT_W'(NV_WRITE_CYC);
                sn.lat_mask = lr.nv_mask;
                sn.lat_idx = lr.nv_idx;
                sn.lat_data = lr.nv_data;
            end
        end
        else if (sr.busy)
        begin
            sn.nvcnt = sr.nvcnt - 1'b1;
            if (sr.nvcnt == qps_pkg::NV_CNT_W'(1))
            begin
                sn.busy = 1'b0;
                for (int i = 0; i < 4; i++)
                begin
                    if (sr.lat_mask[i])
                        sn.stored_setting_reg[sr.lat_idx][i] = sr.lat_data[i];
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sr <= '0;
            sr.taps <= {4{qps_onehot(qps_pkg::WIPER_RST)}};
            sr.stored_setting_reg <= {16{qps_pkg::STORE_RST}};
        end
        else
            sr <= sn;
    end

    assign sda_o = dr_r.sda_o;
    assign sda_oe_n = dr_r.sda_oe_n;
    assign nv_busy = sr.busy;
    assign wiper_tap_sel = sr.taps;

    sequence seq_nv_launch;
        stop_edge && sr.pend_s2 && !sr.busy;
    endsequence

    sequence seq_addr_byte_done;
        lr.stage == qps_pkg::ST_ADDR && lr.bitcnt == qps_pkg::BIT_ACK && lr.ack;
    endsequence

    AST_TAP_ONEHOT: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot(sr.taps[0]) && $onehot(sr.taps[1]) && $onehot(sr.taps[2]) && $onehot(sr.taps[3]))
        else $error("wiper taps not one-hot");
    AST_ADDR_TYPE: assert property (@(posedge scl_in) disable iff (sys_rst)
        seq_addr_byte_done |-> lr.sh[7:4] == qps_pkg::DEV_TYPE)
        else $error("address acknowledged with wrong type");
    AST_ADDR_STRAP: assert property (@(posedge scl_in) disable iff (sys_rst)
        seq_addr_byte_done |-> lr.sh[3:0] == $past(lr.strap_s2))
        else $error("address acknowledged with wrong straps");
    AST_BUSY_NOACK: assert property (@(posedge scl_in) disable iff (sys_rst)
        (link_quiet && lr.stage == qps_pkg::ST_ADDR && lr.bitcnt == qps_pkg::BIT_LAST && lr.busy_s2)
        |=> lr.stage == qps_pkg::ST_IDLE)
        else $error("address acknowledged while busy");
    AST_ACK_DRIVE: assert property (@(posedge scl_in) disable iff (sys_rst)
        (lr.bitcnt == qps_pkg::BIT_ACK && lr.ack) |-> !sda_oe_n)
        else $error("acknowledge not driven on ninth clock");
    AST_INC_STEP: assert property (@(posedge scl_in) disable iff (sys_rst)
        (link_quiet && lr.stage == qps_pkg::ST_INCDEC && sda_in
        && lr.wiper_position_reg[lr.instr[1:0]] != qps_pkg::TAP_MAX)
        |=> lr.wiper_position_reg[lr.instr[1:0]] == $past(lr.wiper_position_reg[lr.instr[1:0]]) + 6'h01)
        else $error("increment step missed");
    AST_DEC_STEP: assert property (@(posedge scl_in) disable iff (sys_rst)
        (link_quiet && lr.stage == qps_pkg::ST_INCDEC && !sda_in
        && lr.wiper_position_reg[lr.instr[1:0]] != 6'h00)
        |=> lr.wiper_position_reg[lr.instr[1:0]] == $past(lr.wiper_position_reg[lr.instr[1:0]]) - 6'h01)
        else $error("decrement step missed");
    AST_INC_SAT: assert property (@(posedge scl_in) disable iff (sys_rst)
        (lr.stage == qps_pkg::ST_INCDEC && sda_in && lr.wiper_position_reg[lr.instr[1:0]] == qps_pkg::TAP_MAX)
        |=> lr.wiper_position_reg[lr.instr[1:0]] == qps_pkg::TAP_MAX)
        else $error("wiper wrapped past top tap");
    AST_NV_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(sr.busy) |-> sr.busy [*8])
        else $error("stored write ended early");
    AST_LOCK_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
        (seq_nv_launch and !sr.wp_s2) |=> !sr.busy)
        else $error("stored write despite write lock");
    AST_BAD_OP: assert property (@(posedge scl_in) disable iff (sys_rst)
        (lr.stage == qps_pkg::ST_INSTR && lr.bitcnt == qps_pkg::BIT_ACK) |-> lr.ack && qps_legal(lr.instr))
        else $error("illegal opcode acknowledged");
endmodule : qps_quad_pot_slave

/* File: sim/qps_master_model.sv */
// Behavioural two-wire bus master for the quad potentiometer slave.
`timescale 1ns/1ps
module qps_master_model (
    output logic scl, // Serial clock, stands high between frames.
    output logic pull, // High while this master pulls data low.
    input wire logic sda // Resolved data wire level.
);
    initial
    begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // One 125 ns bit; data moves only in the low half.
    task automatic clk_bit(input logic b, output logic r);
        scl = 1'b0;
        #31.25 pull = ~b;
        #31.25 scl = 1'b1;
        #31.25 r = sda;
        #31.25;
    endtask : clk_bit
    task automatic start();
        #62.5 pull = 1'b1;
        #62.5;
    endtask : start
    task automatic stop();
        scl = 1'b0;
        #31.25 pull = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 pull = 1'b0;
        #62.5;
    endtask : stop
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = ~r;
    endtask : tx
    task automatic rx(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(1'b0, r);
    endtask : rx
endmodule : qps_master_model

/* File: sim/testbench.sv */
// Self-checking bench for the quad potentiometer serial slave.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module testbench;
    localparam int NV = 200;
    localparam logic [7:0] A = {qps_pkg::DEV_TYPE, 4'h5};
    logic clk = 1'b0;
    // Raised at time zero by the stimulus so the link flops see a reset edge.
    logic sys_rst = 1'b0;
    logic write_lock_n = 1'b1;
    logic [3:0] straps = 4'h5;
    logic scl, pull, sda_o, sda_oe_n, nv_busy, r;
    logic [3:0][63:0] taps;
    logic [7:0] rd;
    logic [2:0] ak;
    int n_fail = 0;
    int checked = 0;
    int busy_cnt = 0;
    // Open-drain wire with pull-up: low when either party pulls.
    wire sda = ~pull & sda_oe_n;
    always #25 clk = ~clk;
    always @(posedge clk) if (nv_busy) busy_cnt <= busy_cnt + 1;
    qps_master_model m_u (.scl(scl), .pull(pull), .sda(sda));
    qps_quad_pot_slave #(.NV_WRITE_CYC(NV)) dut_u (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .address_strap_inputs(straps),
        .write_lock_n(write_lock_n), .nv_busy(nv_busy), .wiper_tap_sel(taps));
    task automatic final_report();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // Mode 1 sends a data byte, mode 2 reads one back.
    task automatic frame(input logic [7:0] adr, input logic [7:0] ins, input int mode, input logic [7:0] wd);
        ak = 3'h0;
        rd = 8'h00;
        m_u.start();
        m_u.tx(adr, ak[2]);
        if (ak[2]) m_u.tx(ins, ak[1]);
        if (ak[1] && mode == 1) m_u.tx(wd, ak[0]);
        if (ak[1] && mode == 2) m_u.rx(rd);
        m_u.stop();
    endtask : frame
    // Address polling; the first try must be refused while the write runs.
    task automatic poll();
        logic a;
        int i;
        for (i = 0; i < 400; i++)
        begin
            m_u.start();
            m_u.tx(A, a);
            m_u.stop();
            if (a) break;
        end
        if (!a)
        begin
            n_fail++;
            final_report();
        end
        `CHK(i > 0, 1'b1)
        `CHK(busy_cnt >= NV, 1'b1)
    endtask : poll
    task automatic t_wiper();
        frame(A, 8'hA1, 1, 8'hEA);
        `CHK(ak, 3'h7)
        repeat (40) @(posedge clk);
        `CHK(taps[1], 64'h1 << 42)
        frame(A, 8'h91, 2, 8'h00);
        `CHK(rd, 8'h2A)
        `CHK(sda_o, 1'b0)
    endtask : t_wiper
    task automatic t_refuse();
        frame({~qps_pkg::DEV_TYPE, 4'h5}, 8'h91, 2, 8'h00);
        `CHK(ak, 3'h0)
        frame({qps_pkg::DEV_TYPE, 4'h6}, 8'h91, 2, 8'h00);
        `CHK(ak, 3'h0)
        frame(A, 8'h31, 2, 8'h00);
        `CHK(ak, 3'h4)
    endtask : t_refuse
    task automatic t_store();
        busy_cnt = 0;
        frame(A, 8'hC6, 1, 8'h15);
        `CHK(ak, 3'h7)
        poll();
        frame(A, 8'hB6, 2, 8'h00);
        `CHK(rd, 8'h15)
    endtask : t_store
    task automatic t_copy();
        frame(A, 8'hD6, 0, 8'h00);
        `CHK(ak, 3'h6)
        repeat (40) @(posedge clk);
        `CHK(taps[2], 64'h1 << 21)
        busy_cnt = 0;
        frame(A, 8'hE1, 0, 8'h00);
        poll();
        frame(A, 8'hB1, 2, 8'h00);
        `CHK(rd, 8'h2A)
    endtask : t_copy
    task automatic t_global();
        frame(A, 8'h14, 0, 8'h00);
        repeat (40) @(posedge clk);
        `CHK(taps, {64'h1, 64'h1 << 21, 64'h1, 64'h1})
        busy_cnt = 0;
        frame(A, 8'h88, 0, 8'h00);
        poll();
        frame(A, 8'hBA, 2, 8'h00);
        `CHK(rd, 8'h15)
    endtask : t_global
    // Pot 3 sits at 0: one clamped step down, three up, one down at the stop.
    task automatic t_step();
        m_u.start();
        m_u.tx(A, ak[2]);
        m_u.tx(8'h23, ak[1]);
        m_u.clk_bit(1'b0, r);
        repeat (3) m_u.clk_bit(1'b1, r);
        m_u.stop();
        repeat (40) @(posedge clk);
        `CHK(taps[3], 64'h1 << 2)
    endtask : t_step
    task automatic t_lock();
        write_lock_n <= 1'b0;
        repeat (4) @(posedge clk);
        frame(A, 8'hC6, 1, 8'h3F);
        repeat (10) @(posedge clk);
        `CHK(nv_busy, 1'b0)
        write_lock_n <= 1'b1;
        repeat (4) @(posedge clk);
        frame(A, 8'hB6, 2, 8'h00);
        `CHK(rd, 8'h15)
    endtask : t_lock
    initial
    begin
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(taps, {4{64'h1}})
        `CHK(sda_oe_n, 1'b1)
        t_wiper();
        t_refuse();
        t_store();
        t_copy();
        t_global();
        t_step();
        t_lock();
        final_report();
    end
endmodule : testbench
